/* File: hdl/spc_pin_cell.sv */
// one serial port pin: gpio / serial function mux with registered outputs
`timescale 1ns/1ps
`default_nettype none

module spc_pin_cell (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic dir,
  input  wire logic func,
  input  wire logic dout,
  input  wire logic ser_out,
  input  wire logic ser_oe,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe_n,
  output logic      pin_rb
);

  typedef struct packed {
    logic out;
    logic oe_n;
    logic rb;
  } spc_cell_t;

  spc_cell_t s_q;
  spc_cell_t s_d;

  // --------------------------------------------------------------------
  // pin mux
  // --------------------------------------------------------------------

  always_comb begin
    s_d    = s_q;
    s_d.rb = pin_in;                 // live level, every mode
    if (!func) begin
      s_d.out  = dout;
      s_d.oe_n = ~dir;
    end else begin
      s_d.out  = ser_out;
      s_d.oe_n = ~ser_oe;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q.out  <= spc_pkg::RST_BIT;
      s_q.oe_n <= 1'h1;              // released after reset
      s_q.rb   <= spc_pkg::RST_BIT;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out  = s_q.out;
  assign pin_oe_n = s_q.oe_n;
  assign pin_rb   = s_q.rb;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------

  property p_gpio_in_released;
    @(posedge clk) disable iff (srst)
      (!func && !dir) |=> pin_oe_n;
  endproperty
  a_gpio_in_released: assert property (p_gpio_in_released)
    else $error("pin driven while gpio input");

  property p_readback;
    @(posedge clk) disable iff (srst)
      1'b1 |=> pin_rb == $past(pin_in);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback does not follow pin");

endmodule

`default_nettype wire

/* File: hdl/spc_top.sv */
// serial port pin control (second register) and interrupt priority control
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none


module spc_top (
  input  wire logic        clk,
  input  wire logic        srst,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        priv_mode,
  // shift engine side
  input  wire logic        eng_simo_out,
  input  wire logic        eng_simo_oe,
  input  wire logic        eng_somi_out,
  input  wire logic        eng_somi_oe,
  input  wire logic        eng_irq_req,
  input  wire logic        eng_seq_busy,
  output logic             eng_run_en,
  output logic             eng_test_mode,
  output logic             eng_simo_in,
  output logic             eng_somi_in,
  // debug
  input  wire logic        debug_suspend,
  // interrupt requests to the cpu
  output logic             irq_level1,
  output logic             irq_level2,
  // pins
  input  wire logic        simo_pin_in,
  output logic             simo_pin_out,
  output logic             simo_pin_oe_n,
  input  wire logic        somi_pin_in,
  output logic             somi_pin_out,
  output logic             somi_pin_oe_n
);

  typedef struct packed {
    logic       simo_dir;
    logic       simo_func;
    logic       simo_dout;
    logic       somi_dir;
    logic       somi_func;
    logic       somi_dout;
    logic       susp_en;
    logic       prio;
    logic       test;
    logic [7:0] rdata;
    logic       irq1;
    logic       irq2;
    logic       run_en;
  } spc_state_t;

  spc_state_t s_q;
  spc_state_t s_d;
  logic       simo_rb;
  logic       somi_rb;
  logic       wr_pc2;
  logic       wr_pri;

  // --------------------------------------------------------------------
  // pin cells
  // --------------------------------------------------------------------

  spc_pin_cell u_simo (
    .clk      (clk),
    .srst     (srst),
    .dir      (s_q.simo_dir),
    .func     (s_q.simo_func),
    .dout     (s_q.simo_dout),
    .ser_out  (eng_simo_out),
    .ser_oe   (eng_simo_oe),
    .pin_in   (simo_pin_in),
    .pin_out  (simo_pin_out),
    .pin_oe_n (simo_pin_oe_n),
    .pin_rb   (simo_rb)
  );

  spc_pin_cell u_somi (
    .clk      (clk),
    .srst     (srst),
    .dir      (s_q.somi_dir),
    .func     (s_q.somi_func),
    .dout     (s_q.somi_dout),
    .ser_out  (eng_somi_out),
    .ser_oe   (eng_somi_oe),
    .pin_in   (somi_pin_in),
    .pin_out  (somi_pin_out),
    .pin_oe_n (somi_pin_oe_n),
    .pin_rb   (somi_rb)
  );

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------

  assign wr_pc2 = reg_wr && (reg_addr == spc_pkg::ADDR_PIN_CTRL_TWO);
  assign wr_pri = reg_wr && (reg_addr == spc_pkg::ADDR_PRI_CTRL);

  always_comb begin
    s_d = s_q;
    if (wr_pc2) begin
      s_d.somi_dir  = reg_wdata[spc_pkg::SOMI_DIR_BIT];
      s_d.somi_func = reg_wdata[spc_pkg::SOMI_FUNC_BIT];
      s_d.somi_dout = reg_wdata[spc_pkg::SOMI_DOUT_BIT];
      s_d.simo_dir  = reg_wdata[spc_pkg::SIMO_DIR_BIT];
      s_d.simo_func = reg_wdata[spc_pkg::SIMO_FUNC_BIT];
      s_d.simo_dout = reg_wdata[spc_pkg::SIMO_DOUT_BIT];
    end
    if (wr_pri && priv_mode) begin
      s_d.susp_en = reg_wdata[spc_pkg::SUSP_EN_BIT];
      s_d.prio  = reg_wdata[spc_pkg::PRIORITY_BIT];
      s_d.test  = reg_wdata[spc_pkg::TEST_BIT];
    end
    // read data, valid the cycle after the strobe only
    s_d.rdata = spc_pkg::RST_BYTE;
    if (reg_rd && reg_addr == spc_pkg::ADDR_PIN_CTRL_TWO) begin
      // live pin levels in bits 7 and 3
      s_d.rdata = {simo_rb, s_q.simo_dout, s_q.simo_func, s_q.simo_dir,
                   somi_rb, s_q.somi_dout, s_q.somi_func, s_q.somi_dir};
    end else if (reg_rd && reg_addr == spc_pkg::ADDR_PRI_CTRL) begin
      s_d.rdata = {s_q.test, s_q.prio, s_q.susp_en, spc_pkg::RSVD_READ};
    end
    s_d.irq1 = eng_irq_req && !s_q.prio;
    s_d.irq2 = eng_irq_req && s_q.prio;
    if (!debug_suspend) begin
      s_d.run_en = 1'b1;
    end else if (s_q.susp_en) begin
      s_d.run_en = 1'b0;
    end else begin
      s_d.run_en = eng_seq_busy;
    end
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q.simo_dir  <= spc_pkg::RST_BIT;
      s_q.simo_func <= spc_pkg::RST_BIT;
      s_q.simo_dout <= spc_pkg::RST_BIT;
      s_q.somi_dir  <= spc_pkg::RST_BIT;
      s_q.somi_func <= spc_pkg::RST_BIT;
      s_q.somi_dout <= spc_pkg::RST_BIT;
      s_q.susp_en   <= spc_pkg::RST_BIT;
      s_q.prio      <= spc_pkg::RST_BIT;
      s_q.test      <= spc_pkg::RST_BIT;
      s_q.rdata     <= spc_pkg::RST_BYTE;
      s_q.irq1      <= spc_pkg::RST_BIT;
      s_q.irq2      <= spc_pkg::RST_BIT;
      s_q.run_en    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata     = s_q.rdata;
  assign irq_level1    = s_q.irq1;
  assign irq_level2    = s_q.irq2;
  assign eng_run_en    = s_q.run_en;
  assign eng_test_mode = s_q.test;   // software keeps it 0
  assign eng_simo_in   = simo_rb;
  assign eng_somi_in   = somi_rb;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_simo_drive;
    (!s_q.simo_func && s_q.simo_dir) |=> (!simo_pin_oe_n && simo_pin_out == $past(s_q.simo_dout));
  endproperty
  a_simo_drive: assert property (p_simo_drive)
    else $error("simo gpio output not driven with data-out");

  property p_pri_locked;
    (wr_pri && !priv_mode) |=> $stable({s_q.test, s_q.prio, s_q.susp_en});
  endproperty
  a_pri_locked: assert property (p_pri_locked)
    else $error("priority register written outside privileged mode");

  property p_pri_write_read;
    (wr_pri && priv_mode) ##1 (reg_rd && reg_addr == spc_pkg::ADDR_PRI_CTRL && !reg_wr)
      |=> reg_rdata[7:5] == $past(reg_wdata[7:5], 2);
  endproperty
  a_pri_write_read: assert property (p_pri_write_read)
    else $error("privileged write not read back");

  // level 1 when priority bit clear
  property p_level1;
    (eng_irq_req && !s_q.prio) |=> (irq_level1 && !irq_level2);
  endproperty
  a_level1: assert property (p_level1)
    else $error("request not on level 1");

  // level 2 when priority bit set
  property p_level2;
    (eng_irq_req && s_q.prio) |=> (irq_level2 && !irq_level1);
  endproperty
  a_level2: assert property (p_level2)
    else $error("request not on level 2");

  property p_no_suspend;
    !debug_suspend |=> eng_run_en;
  endproperty
  a_no_suspend: assert property (p_no_suspend)
    else $error("engine stopped without debug suspend");

  property p_finish_seq;
    (debug_suspend && !s_q.susp_en && eng_seq_busy) |=> eng_run_en;
  endproperty
  a_finish_seq: assert property (p_finish_seq)
    else $error("engine stopped mid sequence");

  property p_freeze;
    (debug_suspend && s_q.susp_en)[*2] |=> !eng_run_en;
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("engine not frozen on suspend");

  property p_rsvd_zero;
    (reg_rd && reg_addr == spc_pkg::ADDR_PRI_CTRL) |=> reg_rdata[spc_pkg::RSVD_MSB:0] == spc_pkg::RSVD_READ;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits not zero");

  // readback bit shows pin, two cycles late (sample must postdate reset)
  property p_simo_rb;
    (reg_rd && reg_addr == spc_pkg::ADDR_PIN_CTRL_TWO && !$past(srst))
      |=> reg_rdata[7] == $past(simo_pin_in, 2);
  endproperty
  a_simo_rb: assert property (p_simo_rb)
    else $error("simo readback wrong");

  property p_somi_rb;
    (reg_rd && reg_addr == spc_pkg::ADDR_PIN_CTRL_TWO && !$past(srst))
      |=> reg_rdata[3] == $past(somi_pin_in, 2);
  endproperty
  a_somi_rb: assert property (p_somi_rb)
    else $error("somi readback wrong");

endmodule

`default_nettype wire

/* File: shared/spc_pkg.sv */
// constants shared by the serial pin and priority control block
package spc_pkg;

  // --------------------------------------------------------------------
  // register offsets (peripheral address space)
  // --------------------------------------------------------------------
  localparam logic [15:0] ADDR_PIN_CTRL_TWO = 16'h103e;
  localparam logic [15:0] ADDR_PRI_CTRL     = 16'h103f;

  // --------------------------------------------------------------------
  // field positions of serial_pin_ctrl_two
  // --------------------------------------------------------------------
  localparam int SOMI_DIR_BIT  = 0;
  localparam int SOMI_FUNC_BIT = 1;
  localparam int SOMI_DOUT_BIT = 2;
  localparam int SOMI_RB_BIT   = 3;
  localparam int SIMO_DIR_BIT  = 4;
  localparam int SIMO_FUNC_BIT = 5;
  localparam int SIMO_DOUT_BIT = 6;
  localparam int SIMO_RB_BIT   = 7;

  // --------------------------------------------------------------------
  // field positions of serial_irq_priority_ctrl
  // --------------------------------------------------------------------
  localparam int SUSP_EN_BIT   = 5;
  localparam int PRIORITY_BIT  = 6;
  localparam int TEST_BIT      = 7;
  localparam int RSVD_MSB      = 4;

  // --------------------------------------------------------------------
  // values after reset and read value of reserved bits
  // --------------------------------------------------------------------
  localparam logic       RST_BIT   = 1'h0;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [4:0] RSVD_READ = 5'h00;

endpackage

/* File: tb/spc_top_test.sv */
// self-checking random testbench of the serial pin and priority control block
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("ERROR at %0t: mismatch, got %h expected %h", $time, got, exp); \
  end \
end

module spc_top_test;
  logic        clk;
  logic        srst;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        priv_mode;
  logic        eng_simo_out;
  logic        eng_simo_oe;
  logic        eng_somi_out;
  logic        eng_somi_oe;
  logic        eng_irq_req;
  logic        eng_seq_busy;
  logic        eng_run_en;
  logic        eng_test_mode;
  logic        eng_simo_in;
  logic        eng_somi_in;
  logic        debug_suspend;
  logic        irq_level1;
  logic        irq_level2;
  logic        simo_pin_in;
  logic        simo_pin_out;
  logic        simo_pin_oe_n;
  logic        somi_pin_in;
  logic        somi_pin_out;
  logic        somi_pin_oe_n;
  int          errors;
  int          compares;
  int          cyc;
  logic [31:0] seed;
  logic [31:0] r;
  logic        nrst;
  // model state
  logic [7:0]  m_pc;
  logic [7:0]  m_pri;
  logic [7:0]  m_rd;
  logic        m_simo_rb;
  logic        m_somi_rb;
  logic        m_simo_out;
  logic        m_simo_oe_n;
  logic        m_somi_out;
  logic        m_somi_oe_n;
  logic        m_irq1;
  logic        m_irq2;
  logic        m_run;

  spc_top spc_top_i (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .priv_mode(priv_mode), .eng_simo_out(eng_simo_out),
    .eng_simo_oe(eng_simo_oe), .eng_somi_out(eng_somi_out), .eng_somi_oe(eng_somi_oe),
    .eng_irq_req(eng_irq_req), .eng_seq_busy(eng_seq_busy), .eng_run_en(eng_run_en),
    .eng_test_mode(eng_test_mode), .eng_simo_in(eng_simo_in), .eng_somi_in(eng_somi_in),
    .debug_suspend(debug_suspend), .irq_level1(irq_level1), .irq_level2(irq_level2),
    .simo_pin_in(simo_pin_in), .simo_pin_out(simo_pin_out), .simo_pin_oe_n(simo_pin_oe_n),
    .somi_pin_in(somi_pin_in), .somi_pin_out(somi_pin_out), .somi_pin_oe_n(somi_pin_oe_n)
  );

  // --------------------------------------------------------------------
  // clock, random source, closing
  // --------------------------------------------------------------------
  always #2 clk = ~clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic close_out();
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // model update and stimulus at each rising edge
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      m_pc = 8'h00;
      m_pri = 8'h00;
      m_rd = 8'h00;
      m_simo_rb = 1'h0;
      m_somi_rb = 1'h0;
      m_simo_out = 1'h0;
      m_somi_out = 1'h0;
      m_simo_oe_n = 1'h1;
      m_somi_oe_n = 1'h1;
      m_irq1 = 1'h0;
      m_irq2 = 1'h0;
      m_run = 1'h1;
    end else begin
      m_rd = 8'h00;
      if (reg_rd && reg_addr == spc_pkg::ADDR_PIN_CTRL_TWO) m_rd = {m_simo_rb, m_pc[6:4], m_somi_rb, m_pc[2:0]};
      if (reg_rd && reg_addr == spc_pkg::ADDR_PRI_CTRL) m_rd = {m_pri[7:5], 5'h00};
      m_simo_out = m_pc[5] ? eng_simo_out : m_pc[6];
      m_simo_oe_n = m_pc[5] ? !eng_simo_oe : !m_pc[4];
      m_somi_out = m_pc[1] ? eng_somi_out : m_pc[2];
      m_somi_oe_n = m_pc[1] ? !eng_somi_oe : !m_pc[0];
      m_irq1 = eng_irq_req & !m_pri[6];
      m_irq2 = eng_irq_req & m_pri[6];
      m_run = !debug_suspend ? 1'h1 : (m_pri[5] ? 1'h0 : eng_seq_busy);
      m_simo_rb = simo_pin_in;
      m_somi_rb = somi_pin_in;
      if (reg_wr && reg_addr == spc_pkg::ADDR_PIN_CTRL_TWO) m_pc = reg_wdata & 8'h77;
      if (reg_wr && reg_addr == spc_pkg::ADDR_PRI_CTRL && priv_mode) m_pri = reg_wdata & 8'he0;
    end
    cyc++;
    r = xs();
    nrst = (cyc < 2) || (cyc >= 6000 && cyc < 6002);
    srst <= nrst;
    reg_wr <= !nrst && r[2:1] == 2'h0;
    reg_rd <= !nrst && r[2:1] == 2'h1;
    reg_addr <= r[4:3] == 2'h0 ? spc_pkg::ADDR_PIN_CTRL_TWO :
                r[4:3] == 2'h3 ? {r[31:24], 8'h40} : spc_pkg::ADDR_PRI_CTRL;
    // test bit always written as 0
    reg_wdata <= r[12:5] & 8'h7f;
    priv_mode <= r[13];
    eng_simo_out <= r[14];
    eng_simo_oe <= r[15];
    eng_somi_out <= r[16];
    eng_somi_oe <= r[17];
    eng_irq_req <= r[18];
    eng_seq_busy <= r[19];
    debug_suspend <= r[20];
    simo_pin_in <= simo_pin_oe_n ? r[21] : simo_pin_out;
    somi_pin_in <= somi_pin_oe_n ? r[22] : somi_pin_out;
  end

  // --------------------------------------------------------------------
  // compare outputs with the model away from the edge
  // --------------------------------------------------------------------
  always @(negedge clk) begin
    if (cyc > 0) begin
      `CHK(reg_rdata, m_rd)
      `CHK(simo_pin_out, m_simo_out)
      `CHK(simo_pin_oe_n, m_simo_oe_n)
      `CHK(somi_pin_out, m_somi_out)
      `CHK(somi_pin_oe_n, m_somi_oe_n)
      `CHK(eng_simo_in, m_simo_rb)
      `CHK(eng_somi_in, m_somi_rb)
      `CHK(irq_level1, m_irq1)
      `CHK(irq_level2, m_irq2)
      `CHK(eng_run_en, m_run)
      `CHK(eng_test_mode, 1'h0)
    end
  end

  // --------------------------------------------------------------------
  // start, main sequence and watchdog
  // --------------------------------------------------------------------
  initial begin
    clk = 1'h0;
    srst = 1'h1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, priv_mode} = '0;
    {eng_simo_out, eng_simo_oe, eng_somi_out, eng_somi_oe, eng_irq_req, eng_seq_busy} = '0;
    {debug_suspend, simo_pin_in, somi_pin_in} = '0;
    errors = 0;
    compares = 0;
    cyc = 0;
    seed = 32'h00005513;
    repeat (12000) @(posedge clk);
    close_out();
  end

  initial begin
    #60000;
    errors++;
    close_out();
  end
endmodule

`default_nettype wire
